// ### common/epd_defs.svh
// constants of the external port, dma and on-chip memory block
`ifndef EPD_DEFS_SVH
`define EPD_DEFS_SVH
`define EPD_ROWS 32768
`define EPD_SZ_16 2'h0
`define EPD_SZ_32 2'h1
`define EPD_SZ_48 2'h2
`define EPD_SZ_64 2'h3
`define EPD_MODE_ASYNC 2'h0
`define EPD_MODE_SYNC 2'h1
`define EPD_MODE_BURST 2'h2
`define EPD_NUM_CH 4'he
`define EPD_HS_CH0 4'ha
`define EPD_HS_CH1 4'hb
`define EPD_EXT_CH0 4'ha
`define EPD_BANK_LSB 26
`define EPD_PAGE_LSB 10
`define EPD_FP_REBIAS 9'h070
`endif

// ### common/epd_pkg.sv
// types of the external port, dma and on-chip memory block
`include "epd_defs.svh"
package epd_pkg;
   typedef enum logic [2:0] {D_IDLE = 3'h0, D_DESC0 = 3'h1, D_DESC1 = 3'h2, D_LOAD = 3'h3,
      D_PIECE = 3'h4, D_STORE = 3'h5, D_NEXT = 3'h6} epd_dma_e;
   typedef enum logic {X_IDLE = 1'b0, X_ACC = 1'b1} epd_ext_e;
   typedef struct packed {
      epd_dma_e dst;
      epd_ext_e xst;
      logic [3:0] ch;
      logic dir;
      logic [1:0] pack;
      logic chain_en;
      logic [15:0] irow, xcnt, xinit, ycnt, ymod, chain;
      logic [31:0] eaddr, last_a, x_addr, fp;
      logic [1:0] idx, rq1, rq2, gnt_b;
      logic [63:0] pbuf, din1, din2, x_dout, c_rdata, dm_rd, pm_rd, tx_d;
      logic go, inflight, own_core, fetch, pair, burst, ack1, ack2;
      logic [7:0] wcnt;
      logic x_oe, x_rd_b, x_wr_b, page_b;
      logic [3:0] bank_b, tx_ch;
      logic c_done, dm_ack, pm_ack, busy, done, tx_v, rx_r;
   } epd_state_s;
endpackage

// ### rtl/epd_top.sv
// external port, dma engine and dual-ported on-chip memory
`timescale 1ns/100ps
`default_nettype none
`include "epd_defs.svh"

module epd_top (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic DM_REQ,
   input wire logic DM_WR,
   input wire logic [1:0] DM_SIZE,
   input wire logic [16:0] DM_ADDR,
   input wire logic [63:0] DM_WDATA,
   output logic DM_ACK,
   output logic [63:0] DM_RDATA,
   input wire logic PM_REQ,
   input wire logic PM_WR,
   input wire logic [1:0] PM_SIZE,
   input wire logic [16:0] PM_ADDR,
   input wire logic [63:0] PM_WDATA,
   output logic PM_ACK,
   output logic [63:0] PM_RDATA,
   input wire logic [31:0] FP_IN,
   input wire logic FP_TO16,
   output logic [31:0] FP_OUT,
   input wire logic CORE_EXT_REQ,
   input wire logic CORE_EXT_WR,
   input wire logic CORE_EXT_FETCH,
   input wire logic CORE_EXT_PAIR,
   input wire logic [31:0] CORE_EXT_ADDR,
   input wire logic [63:0] CORE_EXT_WDATA,
   output logic CORE_EXT_DONE,
   output logic [63:0] CORE_EXT_RDATA,
   input wire logic DMA_START,
   input wire logic [15:0] DMA_DESC,
   output logic DMA_BUSY,
   output logic DMA_DONE,
   input wire logic [1:0] EXT_MODE,
   input wire logic [7:0] EXT_WAIT_STATES,
   input wire logic EXT_ACK,
   input wire logic [63:0] EXT_DATA_IN,
   output logic [63:0] EXT_DATA_OUT,
   output logic EXT_DATA_OE,
   output logic [31:0] EXT_ADDR,
   output logic EXT_RD_B,
   output logic EXT_WR_B,
   output logic [3:0] EXT_BANK_SEL_B,
   output logic EXT_PAGE_HIT_B,
   input wire logic [1:0] EXT_DMA_REQUEST_LINES_B,
   output logic [1:0] EXT_DMA_GRANT_LINES_B,
   output logic PRT_TX_VALID,
   input wire logic PRT_TX_READY,
   output logic [3:0] PRT_TX_CH,
   output logic [63:0] PRT_TX_DATA,
   input wire logic PRT_RX_VALID,
   output logic PRT_RX_READY,
   input wire logic [63:0] PRT_RX_DATA
);
   localparam epd_pkg::epd_state_s ST_RST = '{dst: epd_pkg::D_IDLE, xst: epd_pkg::X_IDLE,
      x_rd_b: 1'b1, x_wr_b: 1'b1, page_b: 1'b1, bank_b: 4'hf, gnt_b: 2'h3, rq1: 2'h3,
      rq2: 2'h3, default: '0};

   epd_pkg::epd_state_s s_reg, s_next;
   // two blocks of 2M bits, 64-bit rows
   logic [63:0] mem [0:1][0:`EPD_ROWS-1];
   logic [63:0] dm_row, pm_row, iop_rd, dm_m, pm_m, pce, pin, xdat;
   logic [15:0] iop_a;
   logic [31:0] a;
   logic [5:0] sh_p, lsh;
   logic [1:0] last_idx;
   logic pm_ok, take_c, wr, x_done, pdone, hs;

   // lane mask of an access width inside a row
   function automatic logic [63:0] lmask(input logic [1:0] sz, input logic h);
      logic [63:0] m;
      m = 64'h0;
      unique case (sz)
         `EPD_SZ_16: m = 64'h0000_0000_0000_ffff;
         `EPD_SZ_32: m = 64'h0000_0000_ffff_ffff;
         `EPD_SZ_48: m = 64'h0000_ffff_ffff_ffff;
         `EPD_SZ_64: m = 64'hffff_ffff_ffff_ffff;
      endcase
      lmask = (sz[1] || !h) ? m : (m << 32);
   endfunction

   // shift of the odd half; wide accesses always start at the low lane
   function automatic logic [5:0] hsh(input logic [1:0] sz, input logic h);
      hsh = {h & ~sz[1], 5'h00};
   endfunction

   // narrow to 16-bit float; tiny values flush to zero, big ones become infinity
   function automatic logic [15:0] f32to16(input logic [31:0] f);
      logic [8:0] e;
      e = {1'b0, f[30:23]} - `EPD_FP_REBIAS;
      if (e[8] || e == 9'h000)
         f32to16 = {f[31], 15'h0000};
      else if (e >= 9'h01f)
         f32to16 = {f[31], 5'h1f, 10'h000};
      else
         f32to16 = {f[31], e[4:0], f[22:13]};
   endfunction

   function automatic logic [31:0] f16to32(input logic [15:0] h);
      logic [8:0] e;
      e = {4'h0, h[14:10]} + `EPD_FP_REBIAS;
      if (h[14:10] == 5'h00)
         f16to32 = {h[15], 31'h0000_0000};
      else if (h[14:10] == 5'h1f)
         f16to32 = {h[15], 8'hff, h[9:0], 13'h0000};
      else
         f16to32 = {h[15], e[7:0], h[9:0], 13'h0000};
   endfunction

   // next state: memory ports, external port, dma sequencer
   always_comb
   begin
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.c_done = 1'b0;
      // ack, data and dma request pins pass two flops before use
      s_next.ack1 = EXT_ACK;
      s_next.ack2 = s_reg.ack1;
      s_next.din1 = EXT_DATA_IN;
      s_next.din2 = s_reg.din1;
      s_next.rq1 = EXT_DMA_REQUEST_LINES_B;
      s_next.rq2 = s_reg.rq1;
      dm_row = mem[DM_ADDR[16]][DM_ADDR[15:1]];
      pm_row = mem[PM_ADDR[16]][PM_ADDR[15:1]];
      dm_m = lmask(DM_SIZE, DM_ADDR[0]);
      pm_m = lmask(PM_SIZE, PM_ADDR[0]);
      // both buses served unless they hit one block
      pm_ok = PM_REQ && !(DM_REQ && DM_ADDR[16] == PM_ADDR[16]);
      s_next.dm_ack = DM_REQ;
      s_next.pm_ack = pm_ok;
      s_next.dm_rd = (dm_row & dm_m) >> hsh(DM_SIZE, DM_ADDR[0]);
      s_next.pm_rd = (pm_row & pm_m) >> hsh(PM_SIZE, PM_ADDR[0]);
      s_next.fp = FP_TO16 ? {16'h0000, f32to16(FP_IN)} : f16to32(FP_IN[15:0]);
      // dma port of the memory, separate from core ports
      iop_a = (s_reg.dst == epd_pkg::D_DESC0) ? s_reg.chain :
         (s_reg.dst == epd_pkg::D_DESC1) ? s_reg.chain + 16'h0001 : s_reg.irow;
      iop_rd = mem[iop_a[15]][iop_a[14:0]];
      // piece position in the packing buffer
      last_idx = (s_reg.pack == `EPD_SZ_16) ? 2'h3 : (s_reg.pack == `EPD_SZ_32) ? 2'h1 : 2'h0;
      sh_p = (s_reg.pack == `EPD_SZ_16) ? {s_reg.idx, 4'h0} :
         (s_reg.pack == `EPD_SZ_32) ? {s_reg.idx[0], 5'h00} : 6'h00;
      pce = (s_reg.pbuf >> sh_p) & lmask(s_reg.pack, 1'b0);
      // narrow pieces ride the half named by the address
      lsh = hsh(s_reg.pack, s_reg.eaddr[0]);
      hs = s_reg.ch == `EPD_HS_CH0 || s_reg.ch == `EPD_HS_CH1;
      x_done = 1'b0;
      xdat = (s_reg.din2 >> lsh) & lmask(s_reg.pack, 1'b0);
      take_c = 1'b0;
      a = CORE_EXT_ADDR;
      wr = 1'b0;
      // external port cycle, core before dma
      unique case (s_reg.xst)
         epd_pkg::X_IDLE:
         begin
            take_c = CORE_EXT_REQ && !s_reg.c_done;
            // program, data and dma paths share one bus
            a = take_c ? CORE_EXT_ADDR : s_reg.eaddr;
            wr = take_c ? CORE_EXT_WR : s_reg.dir;
            s_next.burst = 1'b0;
            if (take_c || s_reg.go)
            begin
               s_next.own_core = take_c;
               s_next.fetch = take_c && CORE_EXT_FETCH;
               s_next.pair = take_c && CORE_EXT_PAIR;
               if (!take_c)
               begin
                  s_next.go = 1'b0;
                  s_next.inflight = 1'b1;
               end
               // pairs and fetches start on the even word
               s_next.x_addr = (take_c && (CORE_EXT_FETCH || CORE_EXT_PAIR)) ?
                  {a[31:1], 1'b0} : a;
               if (take_c)
                  s_next.x_dout = CORE_EXT_PAIR ? CORE_EXT_WDATA :
                     {32'h0000_0000, CORE_EXT_WDATA[31:0]} << {a[0], 5'h00};
               else
                  s_next.x_dout = pce << lsh;
               s_next.x_oe = wr;
               s_next.x_wr_b = !wr;
               s_next.x_rd_b = wr;
               // bank select from high address bits
               s_next.bank_b = ~(4'h1 << a[`EPD_BANK_LSB+1:`EPD_BANK_LSB]);
               // same dram page as the last access
               s_next.page_b = a[31:`EPD_PAGE_LSB] != s_reg.last_a[31:`EPD_PAGE_LSB];
               s_next.last_a = a;
               // back-to-back burst beats skip the waits
               s_next.wcnt = s_reg.burst ? 8'h00 : EXT_WAIT_STATES;
               s_next.xst = epd_pkg::X_ACC;
            end
         end
         epd_pkg::X_ACC:
         begin
            // wait states, then acknowledge in async mode
            if (s_reg.wcnt != 8'h00)
               s_next.wcnt = s_reg.wcnt - 8'h01;
            else if (EXT_MODE != `EPD_MODE_ASYNC || s_reg.ack2)
            begin
               s_next.xst = epd_pkg::X_IDLE;
               s_next.x_rd_b = 1'b1;
               s_next.x_wr_b = 1'b1;
               s_next.x_oe = 1'b0;
               s_next.bank_b = 4'hf;
               s_next.page_b = 1'b1;
               s_next.burst = EXT_MODE == `EPD_MODE_BURST;
               if (s_reg.own_core)
               begin
                  s_next.c_done = 1'b1;
                  // instruction fetch keeps 48 of 64 bits
                  if (s_reg.fetch)
                     s_next.c_rdata = {16'h0000, s_reg.din2[47:0]};
                  else if (s_reg.pair)
                     s_next.c_rdata = s_reg.din2;
                  else
                     s_next.c_rdata = {32'h0000_0000, s_reg.x_addr[0] ?
                        s_reg.din2[63:32] : s_reg.din2[31:0]};
               end
               else
                  x_done = 1'b1;
            end
         end
      endcase
      // dma sequencer uses only its own memory port
      pdone = 1'b0;
      pin = 64'h0;
      unique case (s_reg.dst)
         epd_pkg::D_IDLE:
            if (DMA_START)
            begin
               s_next.chain = DMA_DESC;
               s_next.busy = 1'b1;
               s_next.dst = epd_pkg::D_DESC0;
            end
         epd_pkg::D_DESC0:
         begin
            s_next.eaddr = iop_rd[63:32];
            s_next.irow = iop_rd[31:16];
            s_next.xcnt = iop_rd[15:0];
            s_next.xinit = iop_rd[15:0];
            s_next.dst = epd_pkg::D_DESC1;
         end
         epd_pkg::D_DESC1:
         begin
            s_next.chain_en = iop_rd[55];
            s_next.ch = iop_rd[54:51];
            s_next.pack = iop_rd[50:49];
            s_next.dir = iop_rd[48];
            s_next.ymod = iop_rd[47:32];
            s_next.ycnt = iop_rd[31:16];
            s_next.chain = iop_rd[15:0];
            s_next.idx = 2'h0;
            s_next.pbuf = 64'h0;
            if (iop_rd[54:51] >= `EPD_NUM_CH || s_reg.xcnt == 16'h0000 ||
               iop_rd[31:16] == 16'h0000)
            begin
               s_next.busy = 1'b0;
               s_next.dst = epd_pkg::D_IDLE;
            end
            else
               s_next.dst = iop_rd[48] ? epd_pkg::D_LOAD : epd_pkg::D_PIECE;
         end
         epd_pkg::D_LOAD:
         begin
            s_next.pbuf = iop_rd;
            s_next.dst = epd_pkg::D_PIECE;
         end
         epd_pkg::D_PIECE:
         begin
            // external channels use the bus, others the port stream
            if (s_reg.ch >= `EPD_EXT_CH0)
            begin
               // paced channels wait for their request
               if (!s_reg.go && !s_reg.inflight && (!hs || !s_reg.rq2[s_reg.ch[0]]))
               begin
                  s_next.go = 1'b1;
                  if (hs)
                     s_next.gnt_b[s_reg.ch[0]] = 1'b0;
               end
               if (x_done)
               begin
                  // one word per grant, then release
                  s_next.inflight = 1'b0;
                  s_next.gnt_b = 2'h3;
                  s_next.eaddr = s_reg.eaddr + (s_reg.pack[1] ? 32'h2 : 32'h1);
                  pdone = 1'b1;
                  pin = xdat;
               end
            end
            else if (s_reg.dir)
            begin
               s_next.tx_v = 1'b1;
               s_next.tx_d = pce;
               s_next.tx_ch = s_reg.ch;
               if (s_reg.tx_v && PRT_TX_READY)
               begin
                  s_next.tx_v = 1'b0;
                  pdone = 1'b1;
               end
            end
            else
            begin
               s_next.rx_r = 1'b1;
               if (s_reg.rx_r && PRT_RX_VALID)
               begin
                  s_next.rx_r = 1'b0;
                  pdone = 1'b1;
                  pin = PRT_RX_DATA & lmask(s_reg.pack, 1'b0);
               end
            end
            // pack incoming pieces into one row
            if (pdone)
            begin
               if (!s_reg.dir)
                  s_next.pbuf = s_reg.pbuf | (pin << sh_p);
               s_next.idx = s_reg.idx + 2'h1;
               if (s_reg.idx == last_idx)
               begin
                  s_next.idx = 2'h0;
                  s_next.dst = s_reg.dir ? epd_pkg::D_NEXT : epd_pkg::D_STORE;
               end
            end
         end
         epd_pkg::D_STORE:
            s_next.dst = epd_pkg::D_NEXT;
         epd_pkg::D_NEXT:
         begin
            s_next.pbuf = 64'h0;
            s_next.dst = s_reg.dir ? epd_pkg::D_LOAD : epd_pkg::D_PIECE;
            // two-dimensional walk, then chain or finish
            if (s_reg.xcnt != 16'h0001)
            begin
               s_next.xcnt = s_reg.xcnt - 16'h0001;
               s_next.irow = s_reg.irow + 16'h0001;
            end
            else if (s_reg.ycnt != 16'h0001)
            begin
               s_next.ycnt = s_reg.ycnt - 16'h0001;
               s_next.xcnt = s_reg.xinit;
               s_next.irow = s_reg.irow + 16'h0001 + s_reg.ymod;
            end
            else
            begin
               s_next.done = 1'b1;
               s_next.busy = s_reg.chain_en;
               s_next.dst = s_reg.chain_en ? epd_pkg::D_DESC0 : epd_pkg::D_IDLE;
            end
         end
         default:
            s_next.dst = epd_pkg::D_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
         s_reg <= ST_RST;
      else
         s_reg <= s_next;
   end

   // memory writes; a core write wins a same-row clash with dma
   always_ff @(posedge SYS_CLK)
   begin
      // dma rows land in memory, code or data alike
      if (s_reg.dst == epd_pkg::D_STORE)
         mem[s_reg.irow[15]][s_reg.irow[14:0]] <= s_reg.pbuf;
      // word writes merge into the shared rows
      if (DM_REQ && DM_WR)
         mem[DM_ADDR[16]][DM_ADDR[15:1]] <= (dm_row & ~dm_m) |
            ((DM_WDATA << hsh(DM_SIZE, DM_ADDR[0])) & dm_m);
      if (pm_ok && PM_WR)
         mem[PM_ADDR[16]][PM_ADDR[15:1]] <= (pm_row & ~pm_m) |
            ((PM_WDATA << hsh(PM_SIZE, PM_ADDR[0])) & pm_m);
   end

   // outputs straight from the state register
   assign DM_ACK = s_reg.dm_ack;
   assign DM_RDATA = s_reg.dm_rd;
   assign PM_ACK = s_reg.pm_ack;
   assign PM_RDATA = s_reg.pm_rd;
   assign FP_OUT = s_reg.fp;
   assign CORE_EXT_DONE = s_reg.c_done;
   assign CORE_EXT_RDATA = s_reg.c_rdata;
   assign DMA_BUSY = s_reg.busy;
   assign DMA_DONE = s_reg.done;
   // all 32 address bits reach the pins
   assign EXT_ADDR = s_reg.x_addr;
   assign EXT_DATA_OUT = s_reg.x_dout;
   assign EXT_DATA_OE = s_reg.x_oe;
   assign EXT_RD_B = s_reg.x_rd_b;
   assign EXT_WR_B = s_reg.x_wr_b;
   assign EXT_BANK_SEL_B = s_reg.bank_b;
   assign EXT_PAGE_HIT_B = s_reg.page_b;
   assign EXT_DMA_GRANT_LINES_B = s_reg.gnt_b;
   assign PRT_TX_VALID = s_reg.tx_v;
   assign PRT_TX_CH = s_reg.tx_ch;
   assign PRT_TX_DATA = s_reg.tx_d;
   assign PRT_RX_READY = s_reg.rx_r;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);

   sequence acc_start;
      s_reg.xst == epd_pkg::X_IDLE ##1 s_reg.xst == epd_pkg::X_ACC;
   endsequence

   AST_TWO_BUSES: assert property (PM_REQ && DM_REQ && PM_ADDR[16] != DM_ADDR[16]
      |=> s_reg.pm_ack && s_reg.dm_ack) else $error("split-block core accesses not both served");
   AST_WAIT_STATES: assert property (acc_start ##0 s_reg.wcnt == 8'h03
      |=> (s_reg.xst == epd_pkg::X_ACC) [*3]) else $error("access ended before its waits");
   AST_ACK_HOLD: assert property (s_reg.xst == epd_pkg::X_ACC && s_reg.wcnt == 8'h00 &&
      EXT_MODE == `EPD_MODE_ASYNC && !s_reg.ack2 |=> s_reg.xst == epd_pkg::X_ACC)
      else $error("async access ended without acknowledge");
   AST_BANK: assert property (s_reg.xst == epd_pkg::X_ACC |-> s_reg.bank_b ==
      ~(4'h1 << s_reg.x_addr[`EPD_BANK_LSB+1:`EPD_BANK_LSB])) else $error("bank select wrong");
   AST_FETCH: assert property (s_reg.c_done && s_reg.fetch
      |-> s_reg.c_rdata[63:48] == 16'h0000) else $error("fetch kept unused bits");
   AST_ODD_LANE: assert property (acc_start ##0 !s_reg.own_core && !s_reg.x_wr_b &&
      s_reg.pack == `EPD_SZ_32 && s_reg.x_addr[0] |-> s_reg.x_dout[31:0] == 32'h0)
      else $error("odd word not on upper half");
   AST_GRANT_CAUSE: assert property ($fell(s_reg.gnt_b[0])
      |-> !$past(s_reg.rq2[0])) else $error("grant without request");
   AST_GRANT_REL: assert property (x_done && hs
      |=> s_reg.gnt_b == 2'h3) else $error("grant held after one word");
   AST_DONE: assert property (s_reg.dst == epd_pkg::D_NEXT && s_reg.xcnt == 16'h0001 &&
      s_reg.ycnt == 16'h0001 && !s_reg.chain_en |=> s_reg.done && !s_reg.busy ##1 !s_reg.done)
      else $error("completion pulse missing");
endmodule
`default_nettype wire

// ### test/epd_ext_mem.sv
// external memory model standing on the parallel bus
`timescale 1ns/100ps
`default_nettype none
module epd_ext_mem (
   input wire logic clk,
   input wire logic slow,
   input wire logic [31:0] addr,
   input wire logic rd_b,
   input wire logic wr_b,
   input wire logic oe,
   input wire logic [63:0] dout,
   output logic ack,
   output logic [63:0] din,
   output logic [63:0] last_wr
);
   logic [63:0] held = 64'h0;
   logic [3:0] age = 4'h0;
   // even word low, odd high
   // a released bus shows the inverse so stale data never looks valid
   assign din = !rd_b ? {addr | 32'h1, addr & ~32'h1} ^ {2{32'ha5a5_0000}} : ~held;
   assign ack = !slow || age > 4'h3;
   // access age, read hold value and write capture
   always @(posedge clk)
   begin
      age <= (rd_b && wr_b) ? 4'h0 : age + {3'h0, age < 4'hf};
      if (!rd_b)
         held <= din;
      if (!wr_b && oe)
         last_wr <= dout;
   end
endmodule
`default_nettype wire

// ### test/epd_top_bench.sv
// self-checking bench of the external port, dma and memory block
`timescale 1ns/100ps
`default_nettype none
module epd_top_bench;
   localparam logic [31:0] K = 32'ha5a5_0000;
   logic SYS_CLK = 1'b0, RST_B = 1'b0, slow = 1'b0, pg;
   logic DM_REQ = 1'b0, DM_WR = 1'b0, PM_REQ = 1'b0, PM_WR = 1'b0, FP_TO16 = 1'b0;
   logic CORE_EXT_REQ = 1'b0, CORE_EXT_WR = 1'b0, CORE_EXT_FETCH = 1'b0;
   logic CORE_EXT_PAIR = 1'b0, DMA_START = 1'b0, PRT_TX_READY = 1'b0, EXT_ACK;
   logic [1:0] DM_SIZE = 2'h0, PM_SIZE = 2'h0, EXT_MODE = 2'h1, grant, req_b = 2'h3;
   logic [16:0] DM_ADDR = 17'h0, PM_ADDR = 17'h0;
   logic [63:0] DM_WDATA = 64'h0, PM_WDATA = 64'h0, CORE_EXT_WDATA = 64'h0, r;
   logic [63:0] EXT_DATA_IN, DM_RDATA, PM_RDATA, CORE_EXT_RDATA, EXT_DATA_OUT;
   logic [63:0] PRT_TX_DATA, last_wr;
   logic [31:0] FP_IN = 32'h0, CORE_EXT_ADDR = 32'h0, FP_OUT, EXT_ADDR;
   logic [15:0] DMA_DESC = 16'h0;
   logic [7:0] EXT_WAIT_STATES = 8'h3;
   logic DM_ACK, PM_ACK, CORE_EXT_DONE, DMA_BUSY, DMA_DONE, EXT_DATA_OE, EXT_RD_B;
   logic EXT_WR_B, EXT_PAGE_HIT_B, PRT_TX_VALID;
   logic [3:0] EXT_BANK_SEL_B, PRT_TX_CH;
   int errors = 0, check_count = 0, cyc = 0;

   epd_top i_epd_top (.SYS_CLK, .RST_B, .DM_REQ, .DM_WR, .DM_SIZE, .DM_ADDR, .DM_WDATA,
      .DM_ACK, .DM_RDATA, .PM_REQ, .PM_WR, .PM_SIZE, .PM_ADDR, .PM_WDATA, .PM_ACK,
      .PM_RDATA, .FP_IN, .FP_TO16, .FP_OUT, .CORE_EXT_REQ, .CORE_EXT_WR, .CORE_EXT_FETCH,
      .CORE_EXT_PAIR, .CORE_EXT_ADDR, .CORE_EXT_WDATA, .CORE_EXT_DONE, .CORE_EXT_RDATA,
      .DMA_START, .DMA_DESC, .DMA_BUSY, .DMA_DONE, .EXT_MODE, .EXT_WAIT_STATES, .EXT_ACK,
      .EXT_DATA_IN, .EXT_DATA_OUT, .EXT_DATA_OE, .EXT_ADDR, .EXT_RD_B, .EXT_WR_B,
      .EXT_BANK_SEL_B, .EXT_PAGE_HIT_B, .EXT_DMA_REQUEST_LINES_B(req_b),
      .EXT_DMA_GRANT_LINES_B(grant), .PRT_TX_VALID, .PRT_TX_READY, .PRT_TX_CH,
      .PRT_TX_DATA, .PRT_RX_VALID(1'b0), .PRT_RX_READY(), .PRT_RX_DATA(64'h0));
   epd_ext_mem i_epd_ext_mem (.clk(SYS_CLK), .slow, .addr(EXT_ADDR), .rd_b(EXT_RD_B),
      .wr_b(EXT_WR_B), .oe(EXT_DATA_OE), .dout(EXT_DATA_OUT), .ack(EXT_ACK),
      .din(EXT_DATA_IN), .last_wr);

   // clock and hang guard
   initial
      forever #50 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one core data-bus access, taken at the next rising edge
   task automatic mem(input logic wr, input logic [1:0] sz, input logic [16:0] a,
      input logic [63:0] wd);
      DM_REQ = 1'b1;
      DM_WR = wr;
      DM_SIZE = sz;
      DM_ADDR = a;
      DM_WDATA = wd;
      @(negedge SYS_CLK);
      DM_REQ = 1'b0;
      r = DM_RDATA;
      chk({63'h0, DM_ACK}, 64'h1);
      // one idle edge so a following call never re-raises the request in this step
      @(negedge SYS_CLK);
   endtask

   // one core external access; bank and address are watched while strobes are low
   task automatic ext(input logic wr, f, p, input logic [31:0] a, input logic [63:0] wd);
      int n;
      CORE_EXT_REQ = 1'b1;
      CORE_EXT_WR = wr;
      CORE_EXT_FETCH = f;
      CORE_EXT_PAIR = p;
      CORE_EXT_ADDR = a;
      CORE_EXT_WDATA = wd;
      for (n = 0; n < 60 && CORE_EXT_DONE !== 1'b1; n++)
      begin
         @(negedge SYS_CLK);
         if (EXT_RD_B === 1'b0 || EXT_WR_B === 1'b0)
         begin
            pg = EXT_PAGE_HIT_B;
            chk({60'h0, EXT_BANK_SEL_B}, {60'h0, ~(4'h1 << a[27:26])});
            chk({32'h0, EXT_ADDR}, {32'h0, (f | p) ? a & ~32'h1 : a});
         end
      end
      CORE_EXT_REQ = 1'b0;
      r = CORE_EXT_RDATA;
      chk({63'h0, CORE_EXT_DONE}, 64'h1);
      @(negedge SYS_CLK);
   endtask

   task automatic t_reset();
      chk({58'h0, grant, EXT_RD_B, EXT_WR_B, EXT_DATA_OE, DMA_BUSY}, 64'h3c);
      $display("test reset done");
   endtask

   task automatic t_mem();
      mem(1'b1, 2'h3, 17'h00006, 64'h1122_3344_5566_7788);
      mem(1'b0, 2'h1, 17'h00007, 64'h0);
      chk({32'h0, r[31:0]}, 64'h1122_3344);
      mem(1'b0, 2'h3, 17'h00006, 64'h0);
      chk(r, 64'h1122_3344_5566_7788);
      // both buses on different blocks, then on one block where pm must yield
      DM_REQ = 1'b1;
      DM_WR = 1'b0;
      DM_ADDR = 17'h00006;
      PM_REQ = 1'b1;
      PM_ADDR = 17'h10006;
      @(negedge SYS_CLK);
      chk({62'h0, DM_ACK, PM_ACK}, 64'h3);
      PM_ADDR = 17'h00008;
      @(negedge SYS_CLK);
      DM_REQ = 1'b0;
      PM_REQ = 1'b0;
      chk({62'h0, DM_ACK, PM_ACK}, 64'h2);
      $display("test memory done");
   endtask

   task automatic t_fp();
      FP_IN = 32'h3f80_0000;
      FP_TO16 = 1'b1;
      @(negedge SYS_CLK);
      chk({48'h0, FP_OUT[15:0]}, 64'h3c00);
      FP_IN = 32'h0000_c000;
      FP_TO16 = 1'b0;
      @(negedge SYS_CLK);
      chk({32'h0, FP_OUT}, 64'hc000_0000);
      $display("test fp done");
   endtask

   task automatic t_ext();
      ext(1'b0, 1'b0, 1'b0, 32'h0c00_0005, 64'h0);
      chk({32'h0, r[31:0]}, {32'h0, 32'h0c00_0005 ^ K});
      ext(1'b0, 1'b0, 1'b1, 32'h0c00_0007, 64'h0);
      chk(r, {32'h0c00_0007 ^ K, 32'h0c00_0006 ^ K});
      chk({63'h0, pg}, 64'h0);
      ext(1'b0, 1'b1, 1'b0, 32'h0800_0102, 64'h0);
      chk(r, {16'h0, 16'h0103, 32'h0800_0102 ^ K});
      chk({63'h0, pg}, 64'h1);
      // slow part in asynchronous mode, acknowledge stretches the write
      EXT_MODE = 2'h0;
      slow = 1'b1;
      ext(1'b1, 1'b0, 1'b0, 32'h0800_0103, 64'hdead_beef);
      chk({32'h0, last_wr[63:32]}, 64'hdead_beef);
      $display("test external done");
   endtask

   // stream-out dma of one row in 32-bit pieces with the receiver stalling
   task automatic t_dma();
      int n, k, d;
      k = 0;
      d = 0;
      mem(1'b1, 2'h3, 17'h00020, 64'h0000_0000_0014_0001);
      mem(1'b1, 2'h3, 17'h00022, 64'h0013_0000_0001_0000);
      mem(1'b1, 2'h3, 17'h00028, 64'hcafe_f00d_1234_5678);
      DMA_DESC = 16'h0010;
      DMA_START = 1'b1;
      @(negedge SYS_CLK);
      DMA_START = 1'b0;
      mem(1'b0, 2'h3, 17'h00006, 64'h0);
      chk(r, 64'h1122_3344_5566_7788);
      for (n = 0; n < 80; n++)
      begin
         @(negedge SYS_CLK);
         PRT_TX_READY = n > 4;
         d = d + int'(DMA_DONE === 1'b1);
         if (PRT_TX_VALID === 1'b1 && PRT_TX_READY && k < 2)
         begin
            chk({32'h0, PRT_TX_DATA[31:0]}, k ? 64'hcafe_f00d : 64'h1234_5678);
            chk({60'h0, PRT_TX_CH}, 64'h2);
            k++;
         end
      end
      chk({58'h0, k[1:0], d[1:0], 1'b0, DMA_BUSY}, 64'h24);
      $display("test dma done");
   endtask

   // paced dma: one row out to the bus as two 32-bit words, one per grant
   task automatic t_paced();
      int n, g, d;
      logic [1:0] prev;
      g = 0;
      d = 0;
      prev = 2'h3;
      mem(1'b1, 2'h3, 17'h00024, 64'h0000_0010_0014_0001);
      mem(1'b1, 2'h3, 17'h00026, 64'h0053_0000_0001_0000);
      DMA_DESC = 16'h0012;
      DMA_START = 1'b1;
      @(negedge SYS_CLK);
      DMA_START = 1'b0;
      // request stays low while words remain
      req_b = 2'h2;
      for (n = 0; n < 80; n++)
      begin
         @(negedge SYS_CLK);
         g = g + int'(grant == 2'h2 && prev == 2'h3);
         d = d + int'(DMA_DONE === 1'b1);
         prev = grant;
         if (EXT_WR_B === 1'b0)
            chk(EXT_DATA_OUT, EXT_ADDR[0] ? 64'hcafe_f00d_0000_0000 : 64'h1234_5678);
      end
      req_b = 2'h3;
      chk({58'h0, g[1:0], d[1:0], 1'b0, DMA_BUSY}, 64'h24);
      $display("test paced dma done");
   endtask

   // main sequence
   initial
   begin
      repeat (16) @(negedge SYS_CLK);
      t_reset();
      RST_B = 1'b1;
      @(negedge SYS_CLK);
      t_mem();
      t_fp();
      t_ext();
      t_dma();
      t_paced();
      print_verdict();
   end
endmodule
`default_nettype wire
